// ---- hw/abfp_defs.svh ----
`ifndef ABFP_DEFS_SVH
`define ABFP_DEFS_SVH
// data bus width
`define ABFP_DATA_W 8
// receive and transmit buffer depth in bytes
`define ABFP_DEPTH 16
// reset value of the read and write pointers
`define ABFP_PTR_RST 0
`endif

// ---- hw/abfp_pkg.sv ----
package abfp_pkg;
  // read strobe sequence of the port
  typedef enum logic [1:0] {
    ABFP_RD_IDLE = 2'b00,
    ABFP_RD_DRIVE = 2'b01,
    ABFP_RD_GAP = 2'b10
  } abfp_rd_state_t;
endpackage : abfp_pkg

// ---- hw/abfp_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser for a group of pin levels
module abfp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q; // first stage, read only by the second
  // both stages idle at the pin's inactive level
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= RST_VAL;
      q_o <= RST_VAL;
    end
    else if (ce_i)
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule : abfp_sync
`default_nettype wire

// ---- hw/abfp_port.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "abfp_defs.svh"
// Contract
// - port active only when configuration selects it
// - transfers follow strobe falling edges
// - bus driven only while read strobe low
// - rx_avail_n low when byte readable
// - read strobe fall presents current byte
// - read strobe rise advances to next byte
// - flag high after read, low if more
// - tx_space_n low when byte writable
// - write strobe fall captures bus byte
// - rx flag undriven during reset
// - tx flag undriven during reset
// - wakeup pulse in suspend requests resume
// - wakeup pulse when awake flushes transmit
module abfp_port
  import abfp_pkg::*;
#(
  parameter int DATA_W = `ABFP_DATA_W,
  parameter int DEPTH = `ABFP_DEPTH
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic mode_en_i, // nonvolatile config selects this mode
  input wire logic wakeup_en_i, // remote wakeup enabled in config
  input wire logic suspend_indicator_n_i, // high while the link is suspended
  input wire logic rd_n_i, // read strobe pin
  input wire logic wr_n_i, // write strobe pin
  input wire logic flush_wakeup_n_i, // send-immediate / wakeup pin
  input wire logic [DATA_W-1:0] byte_bus_i,
  output logic [DATA_W-1:0] byte_bus_o,
  output logic byte_bus_oe_o,
  output logic rx_avail_n_o,
  output logic rx_avail_n_oe_o,
  output logic tx_space_n_o,
  output logic tx_space_n_oe_o,
  // receive data arriving from the usb side
  input wire logic rx_valid_i,
  input wire logic [DATA_W-1:0] rx_data_i,
  output logic rx_ready_o,
  // transmit data leaving to the usb side
  output logic tx_valid_o,
  output logic [DATA_W-1:0] tx_data_o,
  input wire logic tx_ready_i,
  output logic flush_o, // one-cycle pulse: send pending data now
  output logic resume_o // one-cycle pulse: request bus resume
);
  localparam int AW = $clog2(DEPTH);
  // pointers wrap by their extra bit, so only powers of two are served
  if (DEPTH < 2 || (1 << AW) != DEPTH || DATA_W < 1)
  begin : g_bad_size
    $error("abfp_port: depth must be a power of two >= 2");
  end

  logic rst_meta_q, rst_n_q; // reset release synchroniser
  logic rd_n_s, wr_n_s, fw_n_s; // synchronised strobes
  logic [DATA_W-1:0] bus_s; // synchronised bus
  logic rd_n_q, wr_n_q, fw_n_q; // previous strobe levels
  logic rd_fall, rd_rise, wr_fall, fw_fall;
  abfp_rd_state_t rd_st_q;
  logic [DATA_W-1:0] rx_mem_q [DEPTH];
  logic [DATA_W-1:0] tx_mem_q [DEPTH];
  logic [AW:0] rx_wp_q, rx_rp_q, tx_wp_q, tx_rp_q;
  logic rx_empty, rx_full, tx_empty, tx_full;

  // pointer difference tells the fill level, shared by both buffers
  function automatic logic [AW:0] fill(input logic [AW:0] wp, input logic [AW:0] rp);
    fill = wp - rp;
  endfunction : fill

  assign rx_empty = (fill(rx_wp_q, rx_rp_q) == '0);
  assign rx_full = (fill(rx_wp_q, rx_rp_q) == (AW+1)'(DEPTH));
  assign tx_empty = (fill(tx_wp_q, tx_rp_q) == '0);
  assign tx_full = (fill(tx_wp_q, tx_rp_q) == (AW+1)'(DEPTH));

  // reset is asserted at once and released through two flops
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // strobes and bus come from pins, so they are synchronised first
  abfp_sync #(.W(3), .RST_VAL(3'b111)) u_sync_strb (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_q),
    .ce_i(ce_i),
    .d_i({rd_n_i, wr_n_i, flush_wakeup_n_i}),
    .q_o({rd_n_s, wr_n_s, fw_n_s})
  );
  // the bus shares the strobe delay, so the byte is settled at the fall
  abfp_sync #(.W(DATA_W), .RST_VAL('0)) u_sync_bus (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_q),
    .ce_i(ce_i),
    .d_i(byte_bus_i),
    .q_o(bus_s)
  );

  // edge detection on the synchronised strobes
  always_ff @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      fw_n_q <= 1'b1;
    end
    else if (ce_i)
    begin
      rd_n_q <= rd_n_s;
      wr_n_q <= wr_n_s;
      fw_n_q <= fw_n_s;
    end
  end
  // strobes only count while the mode is selected
  assign rd_fall = mode_en_i && rd_n_q && !rd_n_s;
  assign rd_rise = mode_en_i && !rd_n_q && rd_n_s;
  assign wr_fall = mode_en_i && wr_n_q && !wr_n_s;
  assign fw_fall = mode_en_i && fw_n_q && !fw_n_s;

  // read sequence: drive on fall, advance and raise flag on rise
  always_ff @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      rd_st_q <= ABFP_RD_IDLE;
    else if (ce_i)
    begin
      case (rd_st_q)
        ABFP_RD_IDLE:
        begin
          if (rd_fall && !rx_avail_n_o)
            rd_st_q <= ABFP_RD_DRIVE;
        end
        ABFP_RD_DRIVE:
        begin
          if (rd_rise)
            rd_st_q <= ABFP_RD_GAP;
        end
        ABFP_RD_GAP:
          rd_st_q <= ABFP_RD_IDLE; // flag held high at least one cycle
        default:
          rd_st_q <= ABFP_RD_IDLE;
      endcase
    end
  end

  // receive buffer pointers; usb side fills, read rise drains
  always_ff @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      rx_wp_q <= (AW+1)'(`ABFP_PTR_RST);
      rx_rp_q <= (AW+1)'(`ABFP_PTR_RST);
    end
    else if (ce_i)
    begin
      if (rx_valid_i && !rx_full)
        rx_wp_q <= rx_wp_q + 1'b1;
      if (rd_st_q == ABFP_RD_DRIVE && rd_rise)
        rx_rp_q <= rx_rp_q + 1'b1;
    end
  end

  // storage: one write port per buffer, addressed by index
  always_ff @(posedge sys_clk_i)
  begin
    if (ce_i && rx_valid_i && !rx_full)
      rx_mem_q[rx_wp_q[AW-1:0]] <= rx_data_i;
    if (ce_i && wr_fall && !tx_full)
      tx_mem_q[tx_wp_q[AW-1:0]] <= bus_s;
  end

  // pin drivers; flags released while in reset or out of mode
  always_ff @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      byte_bus_o <= '0;
      byte_bus_oe_o <= 1'b0;
      rx_avail_n_o <= 1'b1;
      rx_avail_n_oe_o <= 1'b0;
      tx_space_n_o <= 1'b1;
      tx_space_n_oe_o <= 1'b0;
    end
    else if (ce_i)
    begin
      rx_avail_n_oe_o <= mode_en_i;
      tx_space_n_oe_o <= mode_en_i;
      // bus driven from the fall until the rise
      if (rd_fall && !rx_avail_n_o)
      begin
        byte_bus_o <= rx_mem_q[rx_rp_q[AW-1:0]];
        byte_bus_oe_o <= 1'b1;
      end
      else if (rd_n_s || !mode_en_i)
        byte_bus_oe_o <= 1'b0;
      // flag forced high from the rise, low again only if more data
      if (rd_st_q == ABFP_RD_DRIVE && rd_rise)
        rx_avail_n_o <= 1'b1;
      else if (rd_st_q == ABFP_RD_IDLE)
        rx_avail_n_o <= rx_empty || !mode_en_i;
      // space flag drops away on the same edge that takes the filling write
      tx_space_n_o <= tx_full || (wr_fall && fill(tx_wp_q, tx_rp_q) == (AW+1)'(DEPTH-1))
        || !mode_en_i;
    end
  end

  // transmit buffer pointers; write fall fills, usb side drains
  always_ff @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      tx_wp_q <= (AW+1)'(`ABFP_PTR_RST);
      tx_rp_q <= (AW+1)'(`ABFP_PTR_RST);
    end
    else if (ce_i)
    begin
      if (wr_fall && !tx_full)
        tx_wp_q <= tx_wp_q + 1'b1;
      if (tx_ready_i && !tx_empty)
        tx_rp_q <= tx_rp_q + 1'b1;
    end
  end
  assign tx_valid_o = !tx_empty;
  assign tx_data_o = tx_mem_q[tx_rp_q[AW-1:0]];
  assign rx_ready_o = !rx_full;

  // wakeup pin: resume while suspended, flush while awake
  always_ff @(posedge sys_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      resume_o <= 1'b0;
      flush_o <= 1'b0;
    end
    else if (ce_i)
    begin
      resume_o <= fw_fall && suspend_indicator_n_i && wakeup_en_i;
      flush_o <= fw_fall && !suspend_indicator_n_i;
    end
    else
    begin
      resume_o <= 1'b0;
      flush_o <= 1'b0;
    end
  end

  // bus driven only inside a read strobe
  chk_bus_in_read: assert property (@(posedge sys_clk_i) disable iff (!rst_n_q)
    byte_bus_oe_o |-> $past(!rd_n_s) || $past(rd_fall))
    else $error("bus driven outside read strobe");
  // flag raised on the cycle after a read rise
  chk_flag_after_rd: assert property (@(posedge sys_clk_i) disable iff (!rst_n_q)
    (ce_i && rd_st_q == ABFP_RD_DRIVE && rd_rise) |=> rx_avail_n_o)
    else $error("rx flag not raised after read");
  sequence s_wr_edge;
    ce_i && wr_fall && !tx_full;
  endsequence
  // write fall advances the write pointer by one
  chk_wr_capture: assert property (@(posedge sys_clk_i) disable iff (!rst_n_q)
    s_wr_edge |=> tx_wp_q == $past(tx_wp_q) + 1'b1)
    else $error("write byte not captured");
  // read rise advances the read pointer
  chk_rd_advance: assert property (@(posedge sys_clk_i) disable iff (!rst_n_q)
    (ce_i && rd_st_q == ABFP_RD_DRIVE && rd_rise) |=> rx_rp_q == $past(rx_rp_q) + 1'b1)
    else $error("read pointer not advanced");
  // flag low implies data present
  chk_rx_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_n_q)
    (rx_avail_n_oe_o && !rx_avail_n_o) |-> !rx_empty)
    else $error("rx flag low with empty buffer");
  // flag low implies room
  chk_tx_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_n_q)
    (tx_space_n_oe_o && !tx_space_n_o) |-> !tx_full)
    else $error("tx flag low with full buffer");
  // wakeup routing by suspend state
  chk_resume: assert property (@(posedge sys_clk_i) disable iff (!rst_n_q)
    (ce_i && fw_fall && suspend_indicator_n_i && wakeup_en_i) |=> resume_o && !flush_o)
    else $error("resume not requested");
  chk_flush: assert property (@(posedge sys_clk_i) disable iff (!rst_n_q)
    (ce_i && fw_fall && !suspend_indicator_n_i) |=> flush_o && !resume_o)
    else $error("flush not issued");
  // flags released when mode not selected
  chk_mode_off: assert property (@(posedge sys_clk_i) disable iff (!rst_n_q)
    (ce_i && !mode_en_i) |=> !rx_avail_n_oe_o && !tx_space_n_oe_o)
    else $error("flags driven outside mode");
endmodule : abfp_port
`default_nettype wire

// ---- testbench/abfp_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// external controller on the byte fifo pins, with pin-level resolution
module abfp_host_model (
  input wire logic sys_clk_i,
  input wire logic [7:0] bus_o_i, // device read data
  input wire logic bus_oe_i, // device drives the bus
  input wire logic rx_avail_n_i,
  input wire logic rx_oe_i,
  input wire logic tx_space_n_i,
  input wire logic tx_oe_i,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [7:0] bus_pin_o, // resolved bus level
  output logic rx_pin_o, // resolved receive flag
  output logic tx_pin_o // resolved transmit flag
);
  logic drv_q = 1'b0; // host drives the bus
  logic [7:0] dat_q = 8'h00; // host write data
  logic [7:0] last_q = 8'h00; // last bus level seen
  initial rd_n_o = 1'b1;
  initial wr_n_o = 1'b1;
  // flags have pull-ups, so an undriven flag reads high
  assign rx_pin_o = rx_oe_i ? rx_avail_n_i : 1'b1;
  assign tx_pin_o = tx_oe_i ? tx_space_n_i : 1'b1;
  // a released bus has no pull, so show the inverse of its last level
  assign bus_pin_o = bus_oe_i ? bus_o_i : (drv_q ? dat_q : ~last_q);
  always @(posedge sys_clk_i) last_q <= bus_pin_o;
  // write strobe: data set up well before the fall, held past it
  task automatic wr_byte(input logic [7:0] b);
    int n;
    n = 0;
    while (tx_pin_o && n < 50)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    // a full buffer is never strobed: the byte is given up instead
    if (!tx_pin_o)
    begin
      @(posedge sys_clk_i);
      dat_q <= b;
      drv_q <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      wr_n_o <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      wr_n_o <= 1'b1;
      drv_q <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
    end
  endtask : wr_byte
  // read strobe only once the receive flag is low
  task automatic rd_byte(output logic [7:0] b);
    int n;
    n = 0;
    while (rx_pin_o && n < 50)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    // never strobe an empty buffer; the caller then sees an unknown byte
    if (rx_pin_o)
      b = 8'hxx;
    else
    begin
      @(posedge sys_clk_i);
      rd_n_o <= 1'b0;
      repeat (6) @(posedge sys_clk_i);
      b = bus_pin_o;
      rd_n_o <= 1'b1;
    end
  endtask : rd_byte
endmodule : abfp_host_model
`default_nettype wire

// ---- testbench/tb_async_byte_fifo_port.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_async_byte_fifo_port;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic mode_en_i = 1'b1;
  logic wakeup_en_i = 1'b1;
  logic susp_n = 1'b0; // high while suspended
  logic fw_n = 1'b1; // flush / wakeup pin
  logic ce = 1'b1; // clock enable
  logic rx_valid_i = 1'b0;
  logic [7:0] rx_data_i = 8'h00;
  logic tx_ready_i = 1'b0;
  logic rd_n, wr_n, rx_pin, tx_pin, bus_oe, rx_oe, tx_oe, rx_f, tx_f;
  logic rx_ready, tx_valid, flush, resume;
  logic [7:0] bus_pin, bus_o, tx_data, b;
  int err_count = 0;
  int checks = 0;
  initial forever #4 sys_clk_i = ~sys_clk_i;
  abfp_port u_abfp_port (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(ce),
    .mode_en_i(mode_en_i), .wakeup_en_i(wakeup_en_i), .suspend_indicator_n_i(susp_n),
    .rd_n_i(rd_n), .wr_n_i(wr_n), .flush_wakeup_n_i(fw_n), .byte_bus_i(bus_pin),
    .byte_bus_o(bus_o), .byte_bus_oe_o(bus_oe), .rx_avail_n_o(rx_f),
    .rx_avail_n_oe_o(rx_oe), .tx_space_n_o(tx_f), .tx_space_n_oe_o(tx_oe),
    .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_ready_o(rx_ready),
    .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready_i),
    .flush_o(flush), .resume_o(resume));
  abfp_host_model u_abfp_host_model (.sys_clk_i(sys_clk_i), .bus_o_i(bus_o),
    .bus_oe_i(bus_oe), .rx_avail_n_i(rx_f), .rx_oe_i(rx_oe), .tx_space_n_i(tx_f),
    .tx_oe_i(tx_oe), .rd_n_o(rd_n), .wr_n_o(wr_n), .bus_pin_o(bus_pin),
    .rx_pin_o(rx_pin), .tx_pin_o(tx_pin));
  // one comparison, counted
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude
  // usb side hands one byte into the receive buffer
  task automatic push(input logic [7:0] v);
    @(posedge sys_clk_i);
    rx_valid_i <= 1'b1;
    rx_data_i <= v;
    @(posedge sys_clk_i);
    rx_valid_i <= 1'b0;
  endtask : push
  // two reads back to back, flag must bounce high between them
  task automatic t_rx();
    check(rx_pin, 1'b1);
    check(bus_oe, 1'b0);
    push(8'hA5);
    push(8'h3C);
    u_abfp_host_model.rd_byte(b);
    check(b, 8'hA5);
    repeat (3) @(posedge sys_clk_i);
    #1 check(rx_pin, 1'b1);
    check(bus_oe, 1'b0);
    u_abfp_host_model.rd_byte(b);
    check(b, 8'h3C);
    repeat (8) @(posedge sys_clk_i);
    #1 check(rx_pin, 1'b1);
  endtask : t_rx
  // usb side takes one byte: ready stands for one edge, then one idle edge
  task automatic pop();
    tx_ready_i <= 1'b1;
    @(posedge sys_clk_i);
    tx_ready_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : pop
  // writes queued while the usb side stalls, then drained in order
  task automatic t_tx();
    check(tx_pin, 1'b0);
    u_abfp_host_model.wr_byte(8'h5A);
    u_abfp_host_model.wr_byte(8'hC3);
    check(tx_valid, 1'b1);
    check(tx_data, 8'h5A);
    pop();
    check(tx_valid, 1'b1);
    check(tx_data, 8'hC3);
    pop();
    check(tx_valid, 1'b0);
    // fill the whole buffer: the space flag must rise with the last byte
    for (int i = 0; i < 16; i++)
      u_abfp_host_model.wr_byte(8'(8'h10 + i));
    check(tx_pin, 1'b1);
    for (int i = 0; i < 16; i++)
    begin
      check(tx_data, 8'(8'h10 + i));
      pop();
    end
    check({tx_valid, tx_pin}, 8'h00);
  endtask : t_tx
  // low pulse on the flush/wakeup pin, pulses caught over a window
  task automatic t_wake(input logic s, input logic ef, input logic er);
    logic f, r;
    f = 1'b0;
    r = 1'b0;
    @(posedge sys_clk_i);
    susp_n <= s;
    fw_n <= 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      @(posedge sys_clk_i);
      if (i == 4) fw_n <= 1'b1;
      f |= flush;
      r |= resume;
    end
    check(f, ef);
    check(r, er);
  endtask : t_wake
  // reset in mid-run: flags float high, buffers come back empty
  task automatic t_reset();
    u_abfp_host_model.wr_byte(8'h66);
    @(posedge sys_clk_i);
    nrst_i <= 1'b0;
    @(posedge sys_clk_i);
    #1 check({bus_oe, rx_oe, tx_oe, rx_pin, tx_pin}, 8'h03);
    @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    check({tx_valid, rx_pin, tx_pin}, 8'h02);
  endtask : t_reset
  // clock enable low: a byte offered on the usb side must not land
  task automatic t_freeze();
    @(posedge sys_clk_i);
    ce <= 1'b0;
    push(8'h77);
    repeat (4) @(posedge sys_clk_i);
    ce <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    check({rx_pin, rx_ready}, 8'h03);
  endtask : t_freeze
  // mode off: both flags released
  task automatic t_mode();
    @(posedge sys_clk_i);
    mode_en_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    check({rx_oe, tx_oe, rx_pin, tx_pin}, 8'h03);
    mode_en_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    check({rx_oe, tx_oe}, 8'h03);
  endtask : t_mode
  initial
  begin
    repeat (2) @(posedge sys_clk_i);
    #1 check({bus_oe, rx_oe, tx_oe, rx_pin, tx_pin}, 8'h03);
    @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    t_rx();
    t_tx();
    t_wake(1'b0, 1'b1, 1'b0);
    t_wake(1'b1, 1'b0, 1'b1);
    wakeup_en_i <= 1'b0;
    t_wake(1'b1, 1'b0, 1'b0);
    t_reset();
    t_freeze();
    t_mode();
    conclude();
  end
  // watchdog, far beyond the few hundred cycles the run needs
  initial
  begin
    #100us;
    err_count++;
    conclude();
  end
endmodule : tb_async_byte_fifo_port
`default_nettype wire
